// ### src/press_contact_sequence_monitor.sv
// Press contact sequence monitor with ramp-down check and re-arm.
// Assumes contacts, restart and enable-in arrive from pins; start is
// an internal drive command on mclk; config inputs are static.

module press_contact_sequence_monitor
  import press_pkg::*;
#(
  parameter int TICKS = TICK_CYCLES,
  parameter int MAX_MS = MAX_PULSE_MS
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic start,
  input wire logic restart,
  input wire logic top_position_contact,
  input wire logic bottom_position_contact,
  input wire logic press_enable_in,
  input wire logic restart_present,
  input wire logic long_min_pulse,
  output logic press_enable,
  output logic top_zone,
  output logic startup_zone,
  output logic rearm_request,
  output logic sequence_fault,
  output logic rampdown_fault,
  output logic error_flag
);
  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] prev;
    mode_t mode;
    logic top_zone;
    logic startup_zone;
    logic seq_fault;
    logic ramp_fault;
    logic rearm;
    logic press_enable;
    logic error_flag;
    logic start_prev;
    logic start_seen;
  } mon_t;

  mon_t r_reg;
  mon_t r_next;
  logic [1:0] rsync_reg;
  logic rst_sync_n;
  logic t;
  logic b;
  logic pen;
  logic t_rise;
  logic t_fall;
  logic b_rise;
  logic b_fall;
  logic st_rise;
  logic seen_now;
  logic viol_seq;
  logic viol_ramp;

  restart_if rif ();

  // Reset is released synchronously so all state leaves reset together
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rsync_reg <= RSYNC_RESET;
    else
      rsync_reg <= {rsync_reg[0], 1'b1};
  end
  assign rst_sync_n = rsync_reg[1];

  assign rif.ce = ce;
  assign rif.rst_sync_n = rst_sync_n;
  assign rif.level = r_reg.s2[IN_RESTART];
  assign rif.present = restart_present;
  assign rif.long_min = long_min_pulse;

  restart_pulse_timer #(
    .TICKS(TICKS),
    .MAX_MS(MAX_MS)
  ) u_timer (
    .mclk(mclk),
    .rif(rif)
  );

  // Edges compare each synchronised sample with the one before
  assign t = r_reg.s2[IN_TOP];
  assign b = r_reg.s2[IN_BOT];
  assign pen = r_reg.s2[IN_PEN];
  assign t_rise = t & ~r_reg.prev[IN_TOP];
  assign t_fall = ~t & r_reg.prev[IN_TOP];
  assign b_rise = b & ~r_reg.prev[IN_BOT];
  assign b_fall = ~b & r_reg.prev[IN_BOT];
  // Start is a same-clock drive command, so it is used unsynchronised
  assign st_rise = start & ~r_reg.start_prev;
  assign seen_now = r_reg.start_seen | (r_reg.top_zone & st_rise);

  always_comb
  begin
    r_next = r_reg;
    r_next.s1 = {press_enable_in, restart, bottom_position_contact,
                 top_position_contact};
    r_next.s2 = r_reg.s1;
    r_next.prev = r_reg.s2;
    r_next.start_prev = start;
    viol_seq = 1'b0;
    viol_ramp = 1'b0;
    case (r_reg.mode)
      MODE_RUN:
      begin
        if (!pen)
          r_next.mode = MODE_SUSPEND;
        else
        begin
          viol_seq = (t_rise & ~b) | (t_fall & b)
                   | (b_rise & t) | (b_fall & ~t);
          r_next.start_seen = seen_now;
          if (t_fall && r_reg.top_zone)
          begin
            viol_ramp = ~(seen_now | start);
            r_next.start_seen = 1'b0;
          end
          if (t_rise)
          begin
            r_next.top_zone = 1'b1;
            r_next.startup_zone = 1'b0;
          end
          if (t_fall)
            r_next.top_zone = 1'b0;
          if (b_rise)
            r_next.startup_zone = 1'b1;
          if (viol_seq || viol_ramp)
          begin
            r_next.seq_fault = r_reg.seq_fault | viol_seq;
            r_next.ramp_fault = r_reg.ramp_fault | viol_ramp;
            r_next.rearm = 1'b1;
            r_next.top_zone = 1'b0;
            r_next.startup_zone = 1'b0;
            r_next.mode = MODE_FAULT;
          end
        end
      end
      MODE_SUSPEND:
      begin
        // Resume from the contact levels as they stand now
        if (pen)
        begin
          r_next.mode = MODE_RUN;
          r_next.top_zone = t;
          r_next.startup_zone = b & ~t;
          r_next.start_seen = 1'b0;
        end
      end
      MODE_FAULT:
      begin
        // Timer never accepts while the restart input is absent
        if (rif.accept)
        begin
          r_next.seq_fault = 1'b0;
          r_next.ramp_fault = 1'b0;
          r_next.rearm = 1'b0;
          r_next.mode = MODE_SUSPEND;
        end
      end
      default:
      begin
        r_next.rearm = 1'b1;
        r_next.mode = MODE_FAULT;
      end
    endcase
    r_next.press_enable = (r_next.mode == MODE_RUN) &
                          ~r_next.rearm;
    r_next.error_flag = r_next.seq_fault | r_next.ramp_fault;
  end

  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      r_reg <= '0;
      r_reg.s1 <= SYNC_RESET;
      r_reg.mode <= MODE_RESET;
    end
    else if (ce)
      r_reg <= r_next;
  end

  assign press_enable = r_reg.press_enable;
  assign top_zone = r_reg.top_zone;
  assign startup_zone = r_reg.startup_zone;
  assign rearm_request = r_reg.rearm;
  assign sequence_fault = r_reg.seq_fault;
  assign rampdown_fault = r_reg.ramp_fault;
  assign error_flag = r_reg.error_flag;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_sync_n);

  a_top_rise_order: assert property (
    ce && r_reg.mode == MODE_RUN && pen && t_rise && !b
    |=> sequence_fault && !press_enable)
    else $error("top rise with bottom low not flagged");
  a_top_fall_order: assert property (
    ce && r_reg.mode == MODE_RUN && pen && t_fall && b
    |=> sequence_fault)
    else $error("top fall with bottom high not flagged");
  a_bot_rise_order: assert property (
    ce && r_reg.mode == MODE_RUN && pen && b_rise && t
    |=> sequence_fault)
    else $error("bottom rise with top high not flagged");
  a_bot_fall_order: assert property (
    ce && r_reg.mode == MODE_RUN && pen && b_fall && !t
    |=> sequence_fault)
    else $error("bottom fall with top low not flagged");
  a_fault_blocks_enable: assert property (
    (sequence_fault || rampdown_fault) |-> !press_enable)
    else $error("enable high while a fault is latched");
  a_rearm_blocks_enable: assert property (
    rearm_request |-> !press_enable)
    else $error("enable high during re-arm request");
  a_suspend_drops_enable: assert property (
    ce && !pen && !rif.accept
    |=> !press_enable ##0 $stable(sequence_fault))
    else $error("enable input low did not suspend");
  a_rampdown_detect: assert property (
    ce && r_reg.mode == MODE_RUN && pen && !viol_seq && t_fall &&
    r_reg.top_zone && !seen_now && !start
    |=> rampdown_fault && rearm_request)
    else $error("missed ramp-down fault");
  a_restart_clears: assert property (
    ce && r_reg.mode == MODE_FAULT && rif.accept
    |=> !rearm_request && !sequence_fault && !rampdown_fault)
    else $error("valid restart did not clear faults");
  a_no_restart_hold: assert property (
    ce && !restart_present && rearm_request |=> rearm_request)
    else $error("fault cleared without restart input");
endmodule

// ### common/press_pkg.sv
// Constants and types shared by the press contact monitor.
// Assumes a single 10 MHz scan clock.
package press_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_PERIOD_NS = 1_000_000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int MIN_PULSE_SHORT_MS = 100;
  localparam int MIN_PULSE_LONG_MS = 350;
  localparam int MAX_PULSE_MS = 30_000;
  // Bit positions inside the synchroniser vectors
  localparam int IN_TOP = 0;
  localparam int IN_BOT = 1;
  localparam int IN_RESTART = 2;
  localparam int IN_PEN = 3;
  localparam logic [3:0] SYNC_RESET = 4'h0;
  localparam logic [1:0] RSYNC_RESET = 2'h0;
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_SUSPEND = 2'b01,
    MODE_FAULT = 2'b10
  } mode_t;
  localparam mode_t MODE_RESET = MODE_SUSPEND;
endpackage

// ### common/restart_if.sv
// Carrier between the sequence monitor and its restart pulse timer.
// Assumes both ends run on the same scan clock.
interface restart_if;
  logic ce;
  logic rst_sync_n;
  logic level;
  logic present;
  logic long_min;
  logic accept;
  modport timer (
    input ce,
    input rst_sync_n,
    input level,
    input present,
    input long_min,
    output accept
  );
  modport monitor (
    output ce,
    output rst_sync_n,
    output level,
    output present,
    output long_min,
    input accept
  );
endinterface

// ### src/restart_pulse_timer.sv
// Times high pulses on the synchronised restart level in milliseconds.
// Assumes level is already synchronised to mclk.
module restart_pulse_timer
  import press_pkg::*;
#(
  parameter int TICKS = TICK_CYCLES,
  parameter int MAX_MS = MAX_PULSE_MS
)
(
  input wire logic mclk,
  restart_if.timer rif
);
  localparam int PW = $clog2(TICKS);
  localparam int CW = $clog2(MAX_MS + 2);

  typedef struct packed {
    logic [PW-1:0] pre;
    logic [CW-1:0] cnt;
    logic prev;
    logic armed;
    logic high_ok;
    logic accept;
  } tim_t;

  tim_t r_reg;
  tim_t r_next;
  logic [CW-1:0] min_ms;

  assign min_ms = rif.long_min ? CW'(MIN_PULSE_LONG_MS)
                               : CW'(MIN_PULSE_SHORT_MS);
  assign rif.accept = r_reg.accept;

  always_comb
  begin
    r_next = r_reg;
    r_next.prev = rif.level;
    r_next.accept = 1'b0;
    // Only a high that followed an observed low counts as a pulse
    r_next.armed = r_reg.armed | ~rif.level;
    if (rif.level && !r_reg.prev)
    begin
      r_next.high_ok = r_reg.armed;
      // The rising cycle already counts as one cycle of high time
      r_next.pre = PW'(1);
      r_next.cnt = '0;
    end
    else if (rif.level)
    begin
      // Millisecond tick from a cycle prescaler
      if (r_reg.pre == PW'(TICKS - 1))
      begin
        r_next.pre = '0;
        if (r_reg.cnt != CW'(MAX_MS + 1))
          r_next.cnt = r_reg.cnt + 1'b1;
      end
      else
        r_next.pre = r_reg.pre + 1'b1;
    end
    else if (r_reg.prev)
    begin
      r_next.high_ok = 1'b0;
      r_next.cnt = '0;
      // Too short or too long pulses simply fall through here
      r_next.accept = rif.present && r_reg.high_ok &&
                      r_reg.cnt >= min_ms &&
                      r_reg.cnt <= CW'(MAX_MS);
    end
  end

  always_ff @(posedge mclk or negedge rif.rst_sync_n)
  begin
    if (!rif.rst_sync_n)
      r_reg <= '0;
    else if (rif.ce)
      r_reg <= r_next;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rif.rst_sync_n);

  a_accept_in_window: assert property (
    $rose(r_reg.accept) |-> $past(r_reg.cnt) >= $past(min_ms) &&
      $past(r_reg.cnt) <= CW'(MAX_MS))
    else $error("restart accepted outside pulse window");
  a_short_ignored: assert property (
    rif.ce && !rif.level && r_reg.prev && r_reg.cnt < min_ms
    |=> !r_reg.accept)
    else $error("short restart pulse accepted");
endmodule

// ### tb/press_far_side.sv
// Behavioural press contacts and drive command.
// Assumes adv and bad are one-cycle strobes taken on mclk.
module press_far_side
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic adv,
  input wire logic bad,
  input wire logic run,
  output logic top_c,
  output logic bot_c,
  output logic start_cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] step_reg;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      step_reg <= 2'h0;
      top_c <= 1'b1;
      bot_c <= 1'b0;
      start_cmd <= 1'b1;
    end
    else
    begin
      // Drive command, not a pin, so no synchroniser is modelled
      start_cmd <= run;
      if (adv)
      begin
        step_reg <= step_reg + 2'h1;
        if (step_reg[0])
          bot_c <= ~bot_c;
        else
          top_c <= ~top_c;
      end
      else if (bad)
      begin
        // Moves the contact that the legal order would leave alone
        if (step_reg[0])
          top_c <= ~top_c;
        else
          bot_c <= ~bot_c;
      end
    end
  end
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the press contact monitor.
// Assumes a shortened millisecond tick so restart pulses stay short.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import press_pkg::*;
  localparam int TK = 4;
  localparam int MX = 400;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic restart = 1'b0;
  logic pen_in = 1'b1;
  logic present = 1'b1;
  logic long_min = 1'b0;
  logic adv = 1'b0;
  logic bad = 1'b0;
  logic run = 1'b1;
  logic ce = 1'b1;
  logic top_c, bot_c, start_cmd, press_enable, top_zone, startup_zone;
  logic rearm_request, sequence_fault, rampdown_fault, error_flag;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  press_far_side i_far (.mclk(mclk), .rst_n(rst_n), .adv(adv), .bad(bad),
    .run(run), .top_c(top_c), .bot_c(bot_c), .start_cmd(start_cmd));
  press_contact_sequence_monitor #(.TICKS(TK), .MAX_MS(MX)) i_dut
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .start(start_cmd),
    .restart(restart),
    .top_position_contact(top_c),
    .bottom_position_contact(bot_c),
    .press_enable_in(pen_in),
    .restart_present(present),
    .long_min_pulse(long_min),
    .press_enable(press_enable),
    .top_zone(top_zone),
    .startup_zone(startup_zone),
    .rearm_request(rearm_request),
    .sequence_fault(sequence_fault),
    .rampdown_fault(rampdown_fault),
    .error_flag(error_flag)
  );
  initial
    forever #50 mclk = ~mclk;
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #5;
  endtask
  task automatic chk(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask
  // Re-arm request and error flag must follow the two faults
  task automatic chk_out(input logic en, input logic sq, input logic rd);
    chk("press_enable", en, press_enable);
    chk("sequence_fault", sq, sequence_fault);
    chk("rampdown_fault", rd, rampdown_fault);
    chk("rearm_request", sq | rd, rearm_request);
    chk("error_flag", sq | rd, error_flag);
  endtask
  task automatic strobe(input logic legal);
    adv = legal;
    bad = !legal;
    tick(1);
    adv = 1'b0;
    bad = 1'b0;
    tick(8);
  endtask
  task automatic pulse(input int n);
    restart = 1'b1;
    tick(n);
    restart = 1'b0;
    tick(10);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Whole run needs under 9000 cycles
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      print_verdict();
    end
  end
  initial
  begin
    tick(3);
    rst_n = 1'b1;
    tick(10);
    chk_out(1'b1, 1'b0, 1'b0);
    chk("top_zone", 1'b1, top_zone);
    for (int i = 0; i < 4; i++)
    begin
      strobe(1'b0);
      chk_out(1'b0, 1'b1, 1'b0);
      strobe(1'b0);
      if (i == 0)
      begin
        pulse(MIN_PULSE_SHORT_MS * TK - 1);
        chk_out(1'b0, 1'b1, 1'b0);
        pulse((MX + 1) * TK);
        chk_out(1'b0, 1'b1, 1'b0);
      end
      pulse(MIN_PULSE_SHORT_MS * TK);
      chk_out(1'b1, 1'b0, 1'b0);
      strobe(1'b1);
      chk_out(1'b1, 1'b0, 1'b0);
      chk("top_zone", i >= 2, top_zone);
      chk("startup_zone", i == 1, startup_zone);
    end
    run = 1'b0;
    tick(2);
    strobe(1'b1);
    chk_out(1'b0, 1'b0, 1'b1);
    long_min = 1'b1;
    pulse(1000);
    chk_out(1'b0, 1'b0, 1'b1);
    pulse(MIN_PULSE_LONG_MS * TK);
    chk_out(1'b1, 1'b0, 1'b0);
    strobe(1'b1);
    strobe(1'b1);
    strobe(1'b1);
    run = 1'b1;
    tick(2);
    run = 1'b0;
    tick(4);
    strobe(1'b1);
    chk_out(1'b1, 1'b0, 1'b0);
    pen_in = 1'b0;
    tick(8);
    strobe(1'b0);
    chk_out(1'b0, 1'b0, 1'b0);
    strobe(1'b0);
    pen_in = 1'b1;
    tick(8);
    chk_out(1'b1, 1'b0, 1'b0);
    // Clock enable low freezes the monitor through an illegal edge
    ce = 1'b0;
    strobe(1'b0);
    chk_out(1'b1, 1'b0, 1'b0);
    strobe(1'b0);
    ce = 1'b1;
    tick(8);
    chk_out(1'b1, 1'b0, 1'b0);
    present = 1'b0;
    strobe(1'b0);
    strobe(1'b0);
    pulse(MIN_PULSE_LONG_MS * TK);
    chk_out(1'b0, 1'b1, 1'b0);
    rst_n = 1'b0;
    tick(3);
    rst_n = 1'b1;
    tick(10);
    chk_out(1'b1, 1'b0, 1'b0);
    print_verdict();
  end
endmodule
